//--- pkg/pptbp_pkg.sv
// constants and carriers for the passive pass-through burst port
// assumes one add-on clock shared by the port and the local logic
package pptbp_pkg;

    // widths and depths
    localparam int DATA_W   = 32;
    localparam int REGION_W = 2;
    localparam int LANES    = 4;
    localparam int INDEX_W  = 5;
    localparam int CNT_W    = 5;
    localparam int DEPTH    = 16;
    localparam int PTR_W    = 4;

    // data holder / read fifo sits at byte offset 2Ch, index lines carry [6:2]
    localparam logic [7:0]         DATA_REG_OFFSET = 8'h2C;
    localparam logic [INDEX_W-1:0] DATA_REG_INDEX  = DATA_REG_OFFSET[6:2];

    // counts and steps
    localparam logic [CNT_W-1:0]  ONE_WORD     = 5'h01;
    localparam logic [CNT_W-1:0]  NOPF_PACKET  = 5'h02;
    localparam logic [DATA_W-1:0] WORD_STEP    = 32'h0000_0004;

    // values after reset
    localparam logic [LANES-1:0]    LANES_IDLE_N = 4'hF;
    localparam logic [REGION_W-1:0] REGION_RST   = 2'h0;
    localparam logic [DATA_W-1:0]   DATA_RST     = 32'h0000_0000;
    localparam logic [CNT_W-1:0]    CNT_RST      = 5'h00;
    localparam logic [PTR_W-1:0]    PTR_RST      = 4'h0;

    // one pass-through access as recognised on the pci side
    typedef struct packed {
        logic [REGION_W-1:0] region;
        logic                isWrite;
        logic [DATA_W-1:0]   addr;
        logic [CNT_W-1:0]    count;
        logic [LANES-1:0]    lanesN;
    } pptbp_req_t;

    // one posted pci write word with its byte lanes
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [LANES-1:0]  lanesN;
    } pptbp_word_t;

endpackage

//--- design/pptbp_port.sv
// add-on side of the passive pass-through port: status pins, address
// fetch, data holder reads for pci writes and read fifo writes for pci reads
// assumes local logic runs on clk and keeps its own side of the handshake
//
// Behaviour
// - status pins update on the edge after an access is recognised
// - region pins carry the index of the targeted region
// - direction pin low for pci read, high for pci write
// - burst pin low while more than one phase remains
// - address fetch puts the stored address on the bus combinationally
// - read strobe with select drives holder data the following clock
// - ready sampled low completes phase and moves lanes to next word
// - ready sampled high means no completion and no advance
// - burst pin goes high when exactly one word remains
// - local logic sees last phase as burst high with pending low
// - ready on the last phase raises the pending pin
// - a new access is accepted from the clock after pending ends
// - pci read stores address and asks for a read fifo write
// - write strobe with select captures bus data into read fifo
// - ready on a read fifo write completes it and advances pointers
// - without prefetch pci reads split into packets of two or one
`timescale 1ns/1ps
module pptbp_port (
    // clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    // pci side access and posted write words
    input  wire logic                                pciReqValid,
    input  wire pptbp_pkg::pptbp_req_t               pciReq,
    output logic                                     pciReqReady,
    input  wire logic                                pciWrPush,
    input  wire pptbp_pkg::pptbp_word_t              pciWrWord,
    output logic                                     pciRdValid,
    output logic [pptbp_pkg::DATA_W-1:0]             pciRdData,
    input  wire logic                                prefetchEnable,
    // local bus inputs
    input  wire logic                                select_n,
    input  wire logic                                rd_n,
    input  wire logic                                wr_n,
    input  wire logic [pptbp_pkg::INDEX_W-1:0]       regIndex,
    input  wire logic [pptbp_pkg::LANES-1:0]         lane_enable_n,
    input  wire logic                                address_fetch_n,
    input  wire logic                                local_ready_n,
    // local data bus, split three ways
    input  wire logic [pptbp_pkg::DATA_W-1:0]        dqIn,
    output logic [pptbp_pkg::DATA_W-1:0]             dqOut,
    output logic                                     dqOe,
    // status pins
    output logic                                     access_pending_n,
    output logic                                     more_phases_n,
    output logic [pptbp_pkg::REGION_W-1:0]           region_index,
    output logic                                     direction_is_write,
    output logic [pptbp_pkg::LANES-1:0]              valid_lanes_n
);

    typedef enum logic [1:0] {IDLE, ACTIVE, GAP} pptbp_state_t;

    // read bursts without prefetch go out two words at most
    function automatic logic [pptbp_pkg::CNT_W-1:0] packetLen(
        input logic [pptbp_pkg::CNT_W-1:0] total,
        input logic                        isWrite,
        input logic                        prefetch
    );
        logic [pptbp_pkg::CNT_W-1:0] len;
        len = total;
        if (!isWrite && !prefetch && total > pptbp_pkg::NOPF_PACKET) begin
            len = pptbp_pkg::NOPF_PACKET;
        end
        return len;
    endfunction

    pptbp_state_t                        state;
    pptbp_state_t                        next_state;
    pptbp_pkg::pptbp_word_t              wrFifo [pptbp_pkg::DEPTH];
    logic [pptbp_pkg::PTR_W-1:0]         wrPut;
    logic [pptbp_pkg::PTR_W-1:0]         idx;
    logic [pptbp_pkg::PTR_W-1:0]         next_idx;
    logic [pptbp_pkg::CNT_W-1:0]         remain;
    logic [pptbp_pkg::CNT_W-1:0]         next_remain;
    logic [pptbp_pkg::CNT_W-1:0]         totalLeft;
    logic [pptbp_pkg::CNT_W-1:0]         next_totalLeft;
    logic                                isWrite;
    logic [pptbp_pkg::LANES-1:0]         readLanesN;
    logic [pptbp_pkg::DATA_W-1:0]        addrHolder;
    logic [pptbp_pkg::DATA_W-1:0]        dataOut;
    logic                                rdOe;
    logic [pptbp_pkg::DATA_W-1:0]        readWord;

    // decode of the local bus
    wire logic                           takeReq;
    wire logic                           selHit;
    wire logic                           rdHit;
    wire logic                           wrHit;
    wire logic                           fetchOn;
    wire logic                           phaseDone;
    wire logic                           lastDone;
    wire logic                           dirNext;
    wire logic [pptbp_pkg::CNT_W-1:0]    firstLen;
    wire logic [pptbp_pkg::CNT_W-1:0]    gapLen;
    wire logic [pptbp_pkg::LANES-1:0]    next_lanes;
    wire pptbp_pkg::pptbp_word_t         curWord;

    assign takeReq   = pciReqValid && pciReqReady && (pciReq.count != pptbp_pkg::CNT_RST);
    assign selHit    = !select_n && (regIndex == pptbp_pkg::DATA_REG_INDEX)
                       && (lane_enable_n != pptbp_pkg::LANES_IDLE_N);
    assign rdHit     = selHit && !rd_n;
    assign wrHit     = selHit && !wr_n;
    assign fetchOn   = !address_fetch_n;
    assign phaseDone = (state == ACTIVE) && !local_ready_n;
    assign lastDone  = phaseDone && (remain == pptbp_pkg::ONE_WORD);
    assign dirNext   = takeReq ? pciReq.isWrite : isWrite;
    assign firstLen  = packetLen(pciReq.count, pciReq.isWrite, prefetchEnable);
    assign gapLen    = packetLen(totalLeft, isWrite, prefetchEnable);
    assign curWord   = wrFifo[idx];
    assign next_lanes = dirNext ? wrFifo[next_idx].lanesN
                                : (takeReq ? pciReq.lanesN : readLanesN);
    assign dqOut     = fetchOn ? addrHolder : dataOut;
    assign dqOe      = fetchOn || rdOe;

    always_comb begin
        next_state     = state;
        next_idx       = idx;
        next_remain    = remain;
        next_totalLeft = totalLeft;
        unique case (state)
            IDLE: begin
                if (takeReq) begin
                    next_state     = ACTIVE;
                    next_idx       = pptbp_pkg::PTR_RST;
                    next_remain    = firstLen;
                    next_totalLeft = pciReq.count - firstLen;
                end
            end
            ACTIVE: begin
                if (phaseDone) begin
                    next_idx    = idx + 1'b1;
                    next_remain = remain - 1'b1;
                end
                if (lastDone) begin
                    next_state = (totalLeft != pptbp_pkg::CNT_RST) ? GAP : IDLE;
                end
            end
            GAP: begin
                next_state     = ACTIVE;
                next_remain    = gapLen;
                next_totalLeft = totalLeft - gapLen;
            end
            default: begin
                next_state = IDLE;
            end
        endcase
    end

    // sequencing and status pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state            <= IDLE;
            idx              <= pptbp_pkg::PTR_RST;
            remain           <= pptbp_pkg::CNT_RST;
            totalLeft        <= pptbp_pkg::CNT_RST;
            pciReqReady      <= 1'b1;
            access_pending_n <= 1'b1;
            more_phases_n    <= 1'b1;
            valid_lanes_n    <= pptbp_pkg::LANES_IDLE_N;
        end else begin
            state            <= next_state;
            idx              <= next_idx;
            remain           <= next_remain;
            totalLeft        <= next_totalLeft;
            pciReqReady      <= (next_state == IDLE);
            access_pending_n <= (next_state != ACTIVE);
            more_phases_n    <= !((next_state == ACTIVE) && (next_remain > pptbp_pkg::ONE_WORD));
            valid_lanes_n    <= (next_state == ACTIVE) ? next_lanes : pptbp_pkg::LANES_IDLE_N;
        end
    end

    // access attributes and stored address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            isWrite            <= 1'b0;
            readLanesN         <= pptbp_pkg::LANES_IDLE_N;
            region_index       <= pptbp_pkg::REGION_RST;
            direction_is_write <= 1'b0;
            addrHolder         <= pptbp_pkg::DATA_RST;
        end else if (takeReq) begin
            isWrite            <= pciReq.isWrite;
            readLanesN         <= pciReq.lanesN;
            region_index       <= pciReq.region;
            direction_is_write <= pciReq.isWrite;
            addrHolder         <= pciReq.addr;
        end else if (phaseDone) begin
            addrHolder         <= addrHolder + pptbp_pkg::WORD_STEP;
        end
    end

    // posted write words; filled before the access, emptied when it ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPut <= pptbp_pkg::PTR_RST;
        end else if (lastDone && isWrite && next_state == IDLE) begin
            wrPut <= pptbp_pkg::PTR_RST;
        end else if (pciWrPush) begin
            wrPut <= wrPut + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (pciWrPush) begin
            wrFifo[wrPut] <= pciWrWord;
        end
    end

    // holder read towards local logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dataOut <= pptbp_pkg::DATA_RST;
            rdOe    <= 1'b0;
        end else begin
            rdOe <= rdHit;
            if (rdHit) begin
                dataOut <= curWord.data;
            end
        end
    end

    // read fifo write from local logic towards pci
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readWord   <= pptbp_pkg::DATA_RST;
            pciRdValid <= 1'b0;
            pciRdData  <= pptbp_pkg::DATA_RST;
        end else begin
            if (wrHit) begin
                readWord <= dqIn;
            end
            pciRdValid <= phaseDone && !isWrite;
            if (phaseDone && !isWrite) begin
                pciRdData <= wrHit ? dqIn : readWord;
            end
        end
    end

    // checks
    property p_status_follows;
        @(posedge clk) disable iff (!rst_n)
        takeReq |=> !access_pending_n && region_index == $past(pciReq.region)
                    && direction_is_write == $past(pciReq.isWrite);
    endproperty
    a_status_follows: assert property (p_status_follows)
        else $error("status pins did not follow the accepted access");

    property p_burst_pin;
        @(posedge clk) disable iff (!rst_n)
        !access_pending_n |-> more_phases_n == (remain <= pptbp_pkg::ONE_WORD);
    endproperty
    a_burst_pin: assert property (p_burst_pin)
        else $error("burst pin disagrees with words remaining");

    property p_wait_holds;
        @(posedge clk) disable iff (!rst_n)
        (state == ACTIVE) && local_ready_n |=> $stable(remain) && $stable(idx)
                                               && $stable(valid_lanes_n);
    endproperty
    a_wait_holds: assert property (p_wait_holds)
        else $error("phase advanced during a wait state");

    property p_advance;
        @(posedge clk) disable iff (!rst_n)
        phaseDone && remain > pptbp_pkg::ONE_WORD |=> remain == $past(remain) - 1'b1
                                                      && !access_pending_n;
    endproperty
    a_advance: assert property (p_advance)
        else $error("ready did not complete the phase");

    property p_last_ends;
        @(posedge clk) disable iff (!rst_n)
        lastDone |=> access_pending_n && more_phases_n ##1 pciReqReady || !access_pending_n;
    endproperty
    a_last_ends: assert property (p_last_ends)
        else $error("pending stayed low after the last phase");

    property p_fetch_drives;
        @(posedge clk) disable iff (!rst_n)
        fetchOn |-> dqOe && dqOut == addrHolder;
    endproperty
    a_fetch_drives: assert property (p_fetch_drives)
        else $error("stored address not on the bus during fetch");

    property p_holder_read;
        @(posedge clk) disable iff (!rst_n)
        rdHit ##1 address_fetch_n |-> dqOe && dqOut == $past(curWord.data);
    endproperty
    a_holder_read: assert property (p_holder_read)
        else $error("holder data missing the clock after a read");

    property p_fifo_capture;
        @(posedge clk) disable iff (!rst_n)
        wrHit && (state == ACTIVE) && !isWrite && !local_ready_n
            |=> pciRdValid && pciRdData == $past(dqIn);
    endproperty
    a_fifo_capture: assert property (p_fifo_capture)
        else $error("read fifo word not captured from the bus");

    property p_packet_split;
        @(posedge clk) disable iff (!rst_n)
        $fell(access_pending_n) && !direction_is_write && !prefetchEnable
            |-> remain <= pptbp_pkg::NOPF_PACKET;
    endproperty
    a_packet_split: assert property (p_packet_split)
        else $error("read packet longer than two words without prefetch");

    property p_idle_quiet;
        @(posedge clk) disable iff (!rst_n)
        (state == IDLE) && !rdOe && address_fetch_n |-> !dqOe && access_pending_n;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("bus driven while idle");

    c_write_burst: cover property (@(posedge clk) disable iff (!rst_n)
        takeReq && pciReq.isWrite && pciReq.count > pptbp_pkg::NOPF_PACKET ##[1:40] lastDone);
    c_read_wait: cover property (@(posedge clk) disable iff (!rst_n)
        phaseDone && !isWrite ##1 local_ready_n ##1 phaseDone);
    c_read_gap: cover property (@(posedge clk) disable iff (!rst_n)
        state == GAP && access_pending_n ##1 !access_pending_n);
    c_fetch: cover property (@(posedge clk) disable iff (!rst_n)
        fetchOn && !access_pending_n);

endmodule

//--- testbench/pptbp_local_model.sv
// local-logic model for the passive pass-through port: serves each pending
// access with an optional address fetch, either fast or with wait states
// assumes the port's status pins and bus outputs, all sampled on rising clk
`timescale 1ns/1ps
module pptbp_local_model (
    // clock, reset and mode
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         slow,
    input  wire logic                         useAddr,
    // port status and bus outputs
    input  wire logic                         access_pending_n,
    input  wire logic                         more_phases_n,
    input  wire logic                         direction_is_write,
    input  wire logic [pptbp_pkg::LANES-1:0]  valid_lanes_n,
    input  wire logic [pptbp_pkg::DATA_W-1:0] dqOut,
    // local bus drive
    output logic                              select_n,
    output logic                              rd_n,
    output logic                              wr_n,
    output logic [pptbp_pkg::INDEX_W-1:0]     regIndex,
    output logic [pptbp_pkg::LANES-1:0]       lane_enable_n,
    output logic                              address_fetch_n,
    output logic                              local_ready_n,
    output logic [pptbp_pkg::DATA_W-1:0]      dqIn
);
    logic [pptbp_pkg::DATA_W-1:0] gotAddr;
    logic [pptbp_pkg::DATA_W-1:0] rxq[$];
    logic [pptbp_pkg::LANES-1:0]  lnq[$];
    logic                         rdPrev = 1'b0;
    int                           wcnt   = 0;

    task automatic drive(input logic act, input logic dirW);
        select_n      = !act;
        regIndex      = act ? pptbp_pkg::DATA_REG_INDEX : ~pptbp_pkg::DATA_REG_INDEX;
        lane_enable_n = act ? 4'h0 : 4'hF;
        rd_n          = !(act && dirW);
        wr_n          = !(act && !dirW);
        local_ready_n = !act;
        // released bus never shows the stale word
        dqIn          = (act && !dirW) ? 32'h5A00_0000 + 32'(wcnt) : ~dqIn;
    endtask

    task automatic serve();
        logic dirW;
        logic last;
        int   ph;
        dirW = direction_is_write;
        last = 1'b0;
        ph   = 0;
        if (useAddr) begin
            #1 address_fetch_n = 1'b0;
            @(posedge clk);
            gotAddr = dqOut;
            #1 address_fetch_n = 1'b1;
            @(posedge clk);
        end
        while (!last) begin
            #1 drive(!(slow && (ph % 2 == 1)), dirW);
            @(posedge clk);
            if (!local_ready_n) begin
                lnq.push_back(valid_lanes_n);
                if (!wr_n) wcnt++;
                last = more_phases_n;
            end
            ph++;
        end
        #1 drive(1'b0, 1'b0);
    endtask

    initial begin
        address_fetch_n = 1'b1;
        dqIn            = '0;
        drive(1'b0, 1'b0);
        forever begin
            @(posedge clk);
            if (rst_n && !access_pending_n) serve();
        end
    end

    always @(posedge clk) begin
        if (rdPrev) rxq.push_back(dqOut);
        rdPrev <= !rd_n && !select_n;
    end
endmodule

//--- testbench/tb.sv
// self-checking bench for the passive pass-through burst port
// assumes the local-logic model serves every pending access
`timescale 1ns/1ps
module tb;
    logic                           clk = 1'b0;
    logic                           rst_n;
    logic                           pciReqValid;
    pptbp_pkg::pptbp_req_t          pciReq;
    logic                           pciReqReady;
    logic                           pciWrPush;
    pptbp_pkg::pptbp_word_t         pciWrWord;
    logic                           pciRdValid;
    logic [pptbp_pkg::DATA_W-1:0]   pciRdData;
    logic                           prefetchEnable;
    logic                           select_n;
    logic                           rd_n;
    logic                           wr_n;
    logic [pptbp_pkg::INDEX_W-1:0]  regIndex;
    logic [pptbp_pkg::LANES-1:0]    lane_enable_n;
    logic                           address_fetch_n;
    logic                           local_ready_n;
    logic [pptbp_pkg::DATA_W-1:0]   dqIn;
    logic [pptbp_pkg::DATA_W-1:0]   dqOut;
    logic                           dqOe;
    logic                           access_pending_n;
    logic                           more_phases_n;
    logic [pptbp_pkg::REGION_W-1:0] region_index;
    logic                           direction_is_write;
    logic [pptbp_pkg::LANES-1:0]    valid_lanes_n;
    logic                           slow;
    logic                           useAddr;
    logic [pptbp_pkg::DATA_W-1:0]   rdq[$];
    int                             miscompares  = 0;
    int                             total_checks = 0;
    int                             cycles       = 0;
    int                             rdTotal      = 0;

    pptbp_port i_pptbp_port (
        .clk, .rst_n, .pciReqValid, .pciReq, .pciReqReady, .pciWrPush, .pciWrWord,
        .pciRdValid, .pciRdData, .prefetchEnable, .select_n, .rd_n, .wr_n, .regIndex,
        .lane_enable_n, .address_fetch_n, .local_ready_n, .dqIn, .dqOut, .dqOe,
        .access_pending_n, .more_phases_n, .region_index, .direction_is_write, .valid_lanes_n
    );
    pptbp_local_model i_pptbp_local_model (
        .clk, .rst_n, .slow, .useAddr, .access_pending_n, .more_phases_n,
        .direction_is_write, .valid_lanes_n, .dqOut, .select_n, .rd_n, .wr_n, .regIndex,
        .lane_enable_n, .address_fetch_n, .local_ready_n, .dqIn
    );

    always #50 clk = ~clk;

    // run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (pciRdValid) rdq.push_back(pciRdData);
        if (cycles == 3000) begin
            miscompares++;
            results();
        end
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic run_access(input logic [1:0] rgn, input logic wr, input int n,
                              input logic pf, input logic sl, input logic ua);
        logic [31:0] expW[$];
        logic [3:0]  expL[$];
        logic [31:0] adr;
        logic        prev;
        int          k;
        int          pkts;
        prefetchEnable = pf;
        slow           = sl;
        useAddr        = ua;
        adr            = 32'h0000_1000 + 32'(n) * 32'h0000_0100;
        i_pptbp_local_model.rxq.delete();
        i_pptbp_local_model.lnq.delete();
        rdq.delete();
        for (k = 0; k < n; k++) begin
            expW.push_back(wr ? 32'hA500_0000 + 32'(k) * 32'h0000_0101
                              : 32'h5A00_0000 + 32'(rdTotal + k));
            expL.push_back(wr ? 4'(k + 1) : 4'h3);
            if (wr) begin
                pciWrPush = 1'b1;
                pciWrWord = '{data: expW[k], lanesN: expL[k]};
                tick();
            end
        end
        pciWrPush = 1'b0;
        while (!pciReqReady) tick();
        pciReq      = '{region: rgn, isWrite: wr, addr: adr, count: 5'(n), lanesN: 4'h3};
        pciReqValid = 1'b1;
        tick();
        pciReqValid = 1'b0;
        cmp(32'(access_pending_n), '0);
        cmp(32'(more_phases_n), 32'(n == 1));
        cmp(32'(region_index), 32'(rgn));
        cmp(32'(direction_is_write), 32'(wr));
        cmp(32'(valid_lanes_n), 32'(expL[0]));
        k    = 0;
        pkts = 0;
        do begin
            prev = access_pending_n;
            tick();
            if (access_pending_n && !prev) pkts++;
            k++;
        end while (k < 100 && !(access_pending_n && pkts > 0 &&
                   (wr ? i_pptbp_local_model.rxq.size() : rdq.size()) == n));
        cmp(32'(k < 100), 32'h1);
        cmp(32'(pkts), (pf || wr) ? 32'(1'b1) : 32'((n + 1) / 2));
        cmp(32'(i_pptbp_local_model.lnq.size()), 32'(n));
        for (k = 0; k < n; k++) begin
            cmp(wr ? i_pptbp_local_model.rxq[k] : rdq[k], expW[k]);
            cmp(32'(i_pptbp_local_model.lnq[k]), 32'(expL[k]));
        end
        if (ua) cmp(i_pptbp_local_model.gotAddr, adr);
        if (!wr) rdTotal += n;
    endtask

    task automatic t_reset();
        cmp(32'(access_pending_n), 32'(1'b1));
        cmp(32'(more_phases_n), 32'(1'b1));
        cmp(32'(dqOe), '0);
        cmp(32'(valid_lanes_n), 32'(4'hF));
    endtask

    task automatic t_refuse_empty();
        pciReq      = '{region: 2'h2, isWrite: 1'b0, addr: '0, count: 5'h00, lanesN: 4'h0};
        pciReqValid = 1'b1;
        repeat (3) tick();
        pciReqValid = 1'b0;
        cmp(32'(access_pending_n), 32'(1'b1));
    endtask

    task automatic t_wr_fast();
        run_access(2'h3, 1'b1, 4, 1'b1, 1'b0, 1'b1);
    endtask

    task automatic t_wr_wait();
        run_access(2'h0, 1'b1, 5, 1'b1, 1'b1, 1'b0);
    endtask

    task automatic t_rd_fast();
        run_access(2'h1, 1'b0, 4, 1'b1, 1'b0, 1'b1);
    endtask

    task automatic t_rd_packets();
        run_access(2'h2, 1'b0, 5, 1'b0, 1'b1, 1'b0);
    endtask

    task automatic t_back_to_back();
        run_access(2'h2, 1'b1, 1, 1'b1, 1'b0, 1'b0);
        run_access(2'h2, 1'b0, 1, 1'b1, 1'b0, 1'b0);
    endtask

    initial begin
        rst_n          = 1'b0;
        pciReqValid    = 1'b0;
        pciReq         = '0;
        pciWrPush      = 1'b0;
        pciWrWord      = '0;
        prefetchEnable = 1'b1;
        slow           = 1'b0;
        useAddr        = 1'b0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        tick();
        t_reset();
        t_refuse_empty();
        t_wr_fast();
        t_wr_wait();
        t_rd_fast();
        t_rd_packets();
        t_back_to_back();
        results();
    end
endmodule
